// File: rtl/gpio_ports_pkg.sv
// package: widths, reset values, select codes and carriers for the port block
package gpio_ports_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int unsigned P0_W   = 8;
  localparam int unsigned P1_W   = 5;
  localparam int unsigned P2_W   = 3;
  localparam int unsigned P3_W   = 8;
  localparam int unsigned DATA_W = 8;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] P0_LATCH_RST = 8'hFF;
  localparam logic [7:0] P0_DRIVE_RST = 8'h00;
  localparam logic [4:0] P1_LATCH_RST = 5'h00;
  localparam logic [4:0] P1_DIR_RST   = 5'h00;
  localparam logic [2:0] P2_LATCH_RST = 3'h7;
  localparam logic [7:0] P3_LATCH_RST = 8'h00;
  localparam logic [7:0] P3_DIR_RST   = 8'h00;
  localparam logic [7:0] P3_INEN_RST  = 8'hFF;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int unsigned P2_STOP_BIT = 0;
  localparam int unsigned P2_XIN_BIT  = 1;
  localparam int unsigned P2_XOUT_BIT = 2;

  // ----------------------------------------------------------------
  // register selects on the local port
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    SEL_P0_LATCH,
    SEL_P0_DRIVE,
    SEL_P0_PIN,
    SEL_P1_LATCH,
    SEL_P1_DIR,
    SEL_P2_LATCH,
    SEL_P2_PIN,
    SEL_P3_LATCH,
    SEL_P3_DIR,
    SEL_P3_INEN,
    SEL_NONE
  } reg_sel_type;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        wr;
    logic        rd;
    reg_sel_type sel;
    logic [7:0]  wdata;
  } cpu_req_type;

  typedef struct packed {
    logic [7:0] o;
    logic [7:0] oe;
  } pin_drive_type;

endpackage

// File: rtl/gpio_pin_stage.sv
// module: per-bit output stage, open-drain or push-pull, with enable
`timescale 1ns/10ps
`default_nettype none
module gpio_pin_stage #(
  parameter int unsigned W = 8
) (
  // enables
  input  wire logic [W-1:0] i_out_en,
  input  wire logic [W-1:0] i_push_pull,
  input  wire logic [W-1:0] i_force_hiz,
  // data
  input  wire logic [W-1:0] i_latch,
  output logic      [W-1:0] o_out,
  output logic      [W-1:0] o_oe
);

  // open-drain bits only sink: enabled when the latch is low
  always_comb begin
    for (int i = 0; i < W; i++) begin
      o_out[i] = i_latch[i];
      o_oe[i]  = i_out_en[i] & ~i_force_hiz[i] & (i_push_pull[i] | ~i_latch[i]);
    end
  end

endmodule // gpio_pin_stage
`default_nettype wire

// File: rtl/multi_function_io_ports.sv
// module: four general purpose ports with latches, directions and read paths
// ----------------------------------------------------------------
// Behaviour
// RULE1 - port-0 drive bit zero gives open-drain, one gives push-pull
// RULE2 - reset: port-0 latch all ones, drive select all zeros
// RULE3 - software: port-0 input needs latch one then drive select zero
// RULE4 - software: pulse output needs latch equal to its initial level
// RULE5 - ports 0 and 2 read latch and pin levels separately
// RULE6 - port-1 direction bit one drives pin from latch, zero inputs
// RULE7 - reset: port-1 direction and latch cleared, all inputs
// RULE8 - port-1 read gives latch for outputs, pin for inputs
// RULE9 - input bits read pins, so read-modify-write may change latch
// RULE10 - software: timer output on port 1 needs latch one then direction one
// RULE11 - port-2 latch resets to ones; software keeps ones for inputs
// RULE12 - dual-clock mode reserves port-2 bits 1 and 2 for oscillator
// RULE13 - port-2 bit 0 output falling edge sets external interrupt latch
// RULE14 - port-2 reads valid only in bits 2 to 0
// RULE15 - in stop mode port-2 bit 0 floats regardless of hold
// RULE16 - reset: port-3 direction zero, input enable ones, latch zero
// RULE17 - port-3 read: zero, pin, or latch by direction and enable
// RULE18 - port-3 direction bit one drives pin from latch
// RULE19 - software: port-3 digital input clears direction then sets enable
// RULE20 - software: port-3 analog use clears direction and enable
// RULE21 - software: avoid port writes during analog conversion
// RULE22 - latch writes reach pins in the write cycle; reads sample pins
// ----------------------------------------------------------------
`timescale 1ns/10ps
`default_nettype none
module multi_function_io_ports
  import gpio_ports_pkg::*;
(
  // clock and reset
  input  wire logic                        i_clk,
  input  wire logic                        i_rst,
  // cpu access
  input  wire gpio_ports_pkg::cpu_req_type i_req,
  output logic [7:0]                       o_rdata,
  // mode
  input  wire logic                        i_dual_clock,
  input  wire logic                        i_stop_mode,
  input  wire logic                        i_stop_output_hold,
  // pins
  input  wire logic [7:0]                  i_p0_pin,
  output logic      [7:0]                  o_p0_out,
  output logic      [7:0]                  o_p0_oe,
  input  wire logic [4:0]                  i_p1_pin,
  output logic      [4:0]                  o_p1_out,
  output logic      [4:0]                  o_p1_oe,
  input  wire logic [2:0]                  i_p2_pin,
  output logic      [2:0]                  o_p2_out,
  output logic      [2:0]                  o_p2_oe,
  input  wire logic [7:0]                  i_p3_pin,
  output logic      [7:0]                  o_p3_out,
  output logic      [7:0]                  o_p3_oe,
  output logic      [7:0]                  o_p3_in_en,
  // events
  output logic                             o_p20_ext_int
);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [7:0] port0_output_latch_r, port0_output_latch_nxt;
  logic [7:0] port0_drive_type_select_r, port0_drive_type_select_nxt;
  logic [4:0] port1_output_latch_r, port1_output_latch_nxt;
  logic [4:0] port1_direction_r, port1_direction_nxt;
  logic [2:0] port2_output_latch_r, port2_output_latch_nxt;
  logic [7:0] port3_output_latch_r, port3_output_latch_nxt;
  logic [7:0] port3_direction_r, port3_direction_nxt;
  logic [7:0] port3_input_enable_r, port3_input_enable_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic       p20_prev_r, p20_prev_nxt;
  logic       p20_int_r, p20_int_nxt;
  logic [7:0] p0_out_r, p0_oe_r, p3_out_r, p3_oe_r;
  logic [4:0] p1_out_r, p1_oe_r;
  logic [2:0] p2_out_r, p2_oe_r;
  logic [7:0] p0_out_c, p0_oe_c;
  logic [2:0] p2_oe_want;
  logic [2:0] p2_force;
  logic       p20_drv_c;

  function automatic logic [7:0] mix_read(input logic [7:0] lat, input logic [7:0] pin,
                                          input logic [7:0] dir);
    mix_read = (lat & dir) | (pin & ~dir);
  endfunction

  function automatic logic wr_hit(input cpu_req_type r, input reg_sel_type s);
    wr_hit = r.wr & (r.sel == s);
  endfunction

  // ----------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------
  always_comb begin
    port0_output_latch_nxt      = port0_output_latch_r;
    port0_drive_type_select_nxt = port0_drive_type_select_r;
    port1_output_latch_nxt      = port1_output_latch_r;
    port1_direction_nxt         = port1_direction_r;
    port2_output_latch_nxt      = port2_output_latch_r;
    port3_output_latch_nxt      = port3_output_latch_r;
    port3_direction_nxt         = port3_direction_r;
    port3_input_enable_nxt      = port3_input_enable_r;
    if (wr_hit(i_req, SEL_P0_LATCH)) port0_output_latch_nxt = i_req.wdata;
    if (wr_hit(i_req, SEL_P0_DRIVE)) port0_drive_type_select_nxt = i_req.wdata;
    if (wr_hit(i_req, SEL_P1_LATCH)) port1_output_latch_nxt = i_req.wdata[4:0];
    if (wr_hit(i_req, SEL_P1_DIR))   port1_direction_nxt = i_req.wdata[4:0];
    if (wr_hit(i_req, SEL_P2_LATCH)) port2_output_latch_nxt = i_req.wdata[2:0];
    if (wr_hit(i_req, SEL_P3_LATCH)) port3_output_latch_nxt = i_req.wdata;
    if (wr_hit(i_req, SEL_P3_DIR))   port3_direction_nxt = i_req.wdata;
    if (wr_hit(i_req, SEL_P3_INEN))  port3_input_enable_nxt = i_req.wdata;
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      port0_output_latch_r      <= P0_LATCH_RST; // [RULE2]
      port0_drive_type_select_r <= P0_DRIVE_RST; // [RULE2]
      port1_output_latch_r      <= P1_LATCH_RST; // [RULE7]
      port1_direction_r         <= P1_DIR_RST;   // [RULE7]
      port2_output_latch_r      <= P2_LATCH_RST; // [RULE11]
      port3_output_latch_r      <= P3_LATCH_RST; // [RULE16]
      port3_direction_r         <= P3_DIR_RST;   // [RULE16]
      port3_input_enable_r      <= P3_INEN_RST;  // [RULE16]
    end else begin
      port0_output_latch_r      <= port0_output_latch_nxt;
      port0_drive_type_select_r <= port0_drive_type_select_nxt;
      port1_output_latch_r      <= port1_output_latch_nxt;
      port1_direction_r         <= port1_direction_nxt;
      port2_output_latch_r      <= port2_output_latch_nxt;
      port3_output_latch_r      <= port3_output_latch_nxt;
      port3_direction_r         <= port3_direction_nxt;
      port3_input_enable_r      <= port3_input_enable_nxt;
    end
  end

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  // pins are taken directly in the read cycle; the cpu debounces [RULE22]
  always_comb begin
    rdata_nxt = rdata_r;
    if (i_req.rd) begin
      unique case (i_req.sel)
        SEL_P0_LATCH: rdata_nxt = port0_output_latch_r;                 // [RULE5]
        SEL_P0_DRIVE: rdata_nxt = port0_drive_type_select_r;
        SEL_P0_PIN:   rdata_nxt = i_p0_pin;                             // [RULE5]
        // input bits return pins, so bit set/clear can rewrite them [RULE8] [RULE9]
        SEL_P1_LATCH: rdata_nxt = {3'h0, port1_output_latch_r & port1_direction_r
                                  | i_p1_pin & ~port1_direction_r};
        SEL_P1_DIR:   rdata_nxt = {3'h0, port1_direction_r};
        SEL_P2_LATCH: rdata_nxt = {5'h00, port2_output_latch_r};       // [RULE5] [RULE14]
        SEL_P2_PIN:   rdata_nxt = {5'h00, i_p2_pin};                   // [RULE5] [RULE14]
        SEL_P3_LATCH: rdata_nxt = mix_read(port3_output_latch_r,
                                           i_p3_pin & port3_input_enable_r,
                                           port3_direction_r);         // [RULE17]
        SEL_P3_DIR:   rdata_nxt = port3_direction_r;
        SEL_P3_INEN:  rdata_nxt = port3_input_enable_r;
        default:      rdata_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      rdata_r <= 8'h00;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  // ----------------------------------------------------------------
  // output stages
  // ----------------------------------------------------------------
  // oscillator bits are handed over in dual-clock mode [RULE12]
  // stop pin floats in stop mode regardless of the hold bit [RULE15]
  always_comb begin
    p2_force                = {i_dual_clock, i_dual_clock, i_stop_mode};
    p2_oe_want              = ~port2_output_latch_nxt;
    p20_drv_c               = ~port2_output_latch_nxt[P2_STOP_BIT] & ~i_stop_mode;
    p2_oe_want[P2_XIN_BIT]  = ~port2_output_latch_nxt[P2_XIN_BIT] & ~i_dual_clock;
    p2_oe_want[P2_XOUT_BIT] = ~port2_output_latch_nxt[P2_XOUT_BIT] & ~i_dual_clock;
    p2_oe_want[P2_STOP_BIT] = p20_drv_c;
  end

  gpio_pin_stage #(.W(P0_W)) u_p0_stage (
    .i_out_en    (8'hFF),
    .i_push_pull (port0_drive_type_select_nxt), // [RULE1]
    .i_force_hiz (8'h00),
    .i_latch     (port0_output_latch_nxt),
    .o_out       (p0_out_c),
    .o_oe        (p0_oe_c)
  );

  // outputs follow the write cycle's next value so pins change with it [RULE22]
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      p0_out_r <= P0_LATCH_RST;
      p0_oe_r  <= 8'h00;
      p1_out_r <= P1_LATCH_RST;
      p1_oe_r  <= 5'h00;
      p2_out_r <= 3'h0;
      p2_oe_r  <= 3'h0;
      p3_out_r <= P3_LATCH_RST;
      p3_oe_r  <= 8'h00;
    end else begin
      p0_out_r <= p0_out_c;
      p0_oe_r  <= p0_oe_c;                                     // [RULE1]
      p1_out_r <= port1_output_latch_nxt;
      p1_oe_r  <= port1_direction_nxt;                         // [RULE6]
      p2_out_r <= 3'h0;
      p2_oe_r  <= p2_oe_want & ~p2_force;                      // [RULE12] [RULE15]
      p3_out_r <= port3_output_latch_nxt;
      p3_oe_r  <= port3_direction_nxt;                         // [RULE18]
    end
  end

  // ----------------------------------------------------------------
  // stop pin falling edge event
  // ----------------------------------------------------------------
  // driving the stop pin low looks like an external edge to the interrupt
  always_comb begin
    p20_prev_nxt = i_p2_pin[P2_STOP_BIT];
    p20_int_nxt  = p20_prev_r & ~i_p2_pin[P2_STOP_BIT];       // [RULE13]
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      p20_prev_r <= 1'b1;
      p20_int_r  <= 1'b0;
    end else begin
      p20_prev_r <= p20_prev_nxt;
      p20_int_r  <= p20_int_nxt;
    end
  end

  assign o_rdata       = rdata_r;
  assign o_p0_out      = p0_out_r;
  assign o_p0_oe       = p0_oe_r;
  assign o_p1_out      = p1_out_r;
  assign o_p1_oe       = p1_oe_r;
  assign o_p2_out      = p2_out_r;
  assign o_p2_oe       = p2_oe_r;
  assign o_p3_out      = p3_out_r;
  assign o_p3_oe       = p3_oe_r;
  assign o_p3_in_en    = port3_input_enable_r;
  assign o_p20_ext_int = p20_int_r;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_p0_reset_vals: assert property (@(posedge i_clk) $fell(i_rst) |->
    port0_output_latch_r == 8'hFF && port0_drive_type_select_r == 8'h00) // [RULE2]
    else $error("port 0 reset values wrong");
  a_p0_open_drain: assert property (@(posedge i_clk) disable iff (i_rst)
    o_p0_oe[0] |-> (o_p0_out[0] == 1'b0 || $past(port0_drive_type_select_nxt[0]))) // [RULE1]
    else $error("open-drain bit drove high");
  a_p1_reset_in: assert property (@(posedge i_clk) $fell(i_rst) |->
    port1_direction_r == 5'h00 && o_p1_oe == 5'h00) // [RULE7]
    else $error("port 1 not input after reset");
  a_p1_dir_drive: assert property (@(posedge i_clk) disable iff (i_rst)
    wr_hit(i_req, SEL_P1_DIR) |=> o_p1_oe == $past(i_req.wdata[4:0])) // [RULE6]
    else $error("port 1 enable not following direction");
  a_p1_read_mix: assert property (@(posedge i_clk) disable iff (i_rst)
    i_req.rd && i_req.sel == SEL_P1_LATCH && port1_direction_r == 5'h00
    |=> o_rdata == {3'h0, $past(i_p1_pin)}) // [RULE8]
    else $error("port 1 input read wrong");
  a_p2_reset_ones: assert property (@(posedge i_clk) $fell(i_rst) |->
    port2_output_latch_r == 3'h7) // [RULE11]
    else $error("port 2 latch not ones");
  a_p2_stop_float: assert property (@(posedge i_clk) disable iff (i_rst)
    i_stop_mode ##1 i_stop_mode |-> !o_p2_oe[0]) // [RULE15]
    else $error("stop pin driven in stop mode");
  a_p2_osc_free: assert property (@(posedge i_clk) disable iff (i_rst)
    $past(i_dual_clock) |-> o_p2_oe[2:1] == 2'b00) // [RULE12]
    else $error("oscillator pins driven");
  a_p2_read_upper: assert property (@(posedge i_clk) disable iff (i_rst)
    i_req.rd && i_req.sel == SEL_P2_PIN |=> o_rdata[7:3] == 5'h00) // [RULE14]
    else $error("port 2 upper read bits not zero");
  a_p20_fall_int: assert property (@(posedge i_clk) disable iff (i_rst)
    $fell(i_p2_pin[0]) |=> o_p20_ext_int) // [RULE13]
    else $error("stop pin edge missed");
  a_p3_read_off: assert property (@(posedge i_clk) disable iff (i_rst)
    i_req.rd && i_req.sel == SEL_P3_LATCH && port3_direction_r == 8'h00
    && port3_input_enable_r == 8'h00 |=> o_rdata == 8'h00) // [RULE17]
    else $error("port 3 disabled read not zero");
  a_p3_reset_vals: assert property (@(posedge i_clk) $fell(i_rst) |->
    o_p3_in_en == 8'hFF && o_p3_oe == 8'h00) // [RULE16]
    else $error("port 3 reset values wrong");
  a_p3_dir_drive: assert property (@(posedge i_clk) disable iff (i_rst)
    wr_hit(i_req, SEL_P3_DIR) |=> o_p3_oe == $past(i_req.wdata)) // [RULE18]
    else $error("port 3 enable not following direction");
  a_p0_pin_read: assert property (@(posedge i_clk) disable iff (i_rst)
    i_req.rd && i_req.sel == SEL_P0_PIN |=> o_rdata == $past(i_p0_pin)) // [RULE5] [RULE22]
    else $error("port 0 pin read wrong");

  c_p0_write: cover property (@(posedge i_clk) wr_hit(i_req, SEL_P0_LATCH));
  c_p1_out:   cover property (@(posedge i_clk) o_p1_oe != 5'h00);
  c_p20_int:  cover property (@(posedge i_clk) o_p20_ext_int);
  // the hold bit must not keep the stop pin driven
  c_stop:     cover property (@(posedge i_clk) i_stop_mode && i_stop_output_hold && !o_p2_oe[0]);

endmodule // multi_function_io_ports
`default_nettype wire

// File: testbench/pin_partner.sv
// bench model: board-side sources that meet the four ports at the pins
`timescale 1ns/10ps
`default_nettype none
module pin_partner (
  // device side
  input  wire logic [7:0] i_p0_out,
  input  wire logic [7:0] i_p0_oe,
  input  wire logic [4:0] i_p1_out,
  input  wire logic [4:0] i_p1_oe,
  input  wire logic [2:0] i_p2_out,
  input  wire logic [2:0] i_p2_oe,
  input  wire logic [7:0] i_p3_out,
  input  wire logic [7:0] i_p3_oe,
  // board sources, resistive, so any driving device bit wins
  input  wire logic [7:0] i_p0_src,
  input  wire logic [4:0] i_p1_src,
  input  wire logic [2:0] i_p2_src,
  input  wire logic [7:0] i_p3_src,
  // resolved pin levels
  output logic      [7:0] o_p0_pin,
  output logic      [4:0] o_p1_pin,
  output logic      [2:0] o_p2_pin,
  output logic      [7:0] o_p3_pin
);
  // a pin the device does not drive shows the board source, never a stale level
  assign o_p0_pin = (i_p0_oe & i_p0_out) | (~i_p0_oe & i_p0_src);
  assign o_p1_pin = (i_p1_oe & i_p1_out) | (~i_p1_oe & i_p1_src);
  assign o_p2_pin = (i_p2_oe & i_p2_out) | (~i_p2_oe & i_p2_src);
  assign o_p3_pin = (i_p3_oe & i_p3_out) | (~i_p3_oe & i_p3_src);
endmodule // pin_partner
`default_nettype wire

// File: testbench/tb_top.sv
// testbench: scenario tasks for the four-port block
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import gpio_ports_pkg::*;
  logic        i_clk, i_rst, i_dual_clock, i_stop_mode, i_stop_output_hold, o_p20_ext_int;
  cpu_req_type i_req;
  logic [7:0]  o_rdata, i_p0_pin, o_p0_out, o_p0_oe, p0_src;
  logic [4:0]  i_p1_pin, o_p1_out, o_p1_oe, p1_src;
  logic [2:0]  i_p2_pin, o_p2_out, o_p2_oe, p2_src;
  logic [7:0]  i_p3_pin, o_p3_out, o_p3_oe, o_p3_in_en, p3_src;
  int          fails, compares;

  multi_function_io_ports u_dut (.i_clk(i_clk), .i_rst(i_rst), .i_req(i_req),
    .o_rdata(o_rdata), .i_dual_clock(i_dual_clock), .i_stop_mode(i_stop_mode),
    .i_stop_output_hold(i_stop_output_hold), .i_p0_pin(i_p0_pin), .o_p0_out(o_p0_out),
    .o_p0_oe(o_p0_oe), .i_p1_pin(i_p1_pin), .o_p1_out(o_p1_out), .o_p1_oe(o_p1_oe),
    .i_p2_pin(i_p2_pin), .o_p2_out(o_p2_out), .o_p2_oe(o_p2_oe), .i_p3_pin(i_p3_pin),
    .o_p3_out(o_p3_out), .o_p3_oe(o_p3_oe), .o_p3_in_en(o_p3_in_en),
    .o_p20_ext_int(o_p20_ext_int));

  pin_partner u_pins (.i_p0_out(o_p0_out), .i_p0_oe(o_p0_oe), .i_p1_out(o_p1_out),
    .i_p1_oe(o_p1_oe), .i_p2_out(o_p2_out), .i_p2_oe(o_p2_oe), .i_p3_out(o_p3_out),
    .i_p3_oe(o_p3_oe), .i_p0_src(p0_src), .i_p1_src(p1_src), .i_p2_src(p2_src),
    .i_p3_src(p3_src), .o_p0_pin(i_p0_pin), .o_p1_pin(i_p1_pin), .o_p2_pin(i_p2_pin),
    .o_p3_pin(i_p3_pin));

  always #2.5 i_clk = ~i_clk;

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic end_of_test();
    if (fails == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  // one idle cycle between requests so no strobe is set twice in a time step
  task automatic wr(input reg_sel_type sel, input logic [7:0] d);
    @(posedge i_clk);
    #1;
    i_req.wr = 1'b1;
    i_req.sel = sel;
    i_req.wdata = d;
    @(posedge i_clk);
    #1;
    i_req.wr = 1'b0;
    i_req.sel = SEL_NONE;
  endtask

  task automatic rd(input reg_sel_type sel, output logic [7:0] d);
    @(posedge i_clk);
    #1;
    i_req.rd = 1'b1;
    i_req.sel = sel;
    @(posedge i_clk);
    #1;
    i_req.rd = 1'b0;
    i_req.sel = SEL_NONE;
    d = o_rdata;
  endtask

  task automatic settle();
    repeat (2) @(posedge i_clk);
    #1;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    logic [7:0] d;
    chk("p0_out", 8'hFF, o_p0_out);
    chk("p0_oe", 8'h00, o_p0_oe);
    chk("p1_oe", 8'h00, {3'h0, o_p1_oe});
    chk("p1_out", 8'h00, {3'h0, o_p1_out});
    chk("p3_oe", 8'h00, o_p3_oe);
    chk("p3_out", 8'h00, o_p3_out);
    chk("p3_in_en", 8'hFF, o_p3_in_en);
    rd(SEL_P0_LATCH, d);
    chk("p0_latch", 8'hFF, d);
    rd(SEL_P0_DRIVE, d);
    chk("p0_drive", 8'h00, d);
    rd(SEL_P1_DIR, d);
    chk("p1_dir", 8'h00, d);
    rd(SEL_P2_LATCH, d);
    chk("p2_latch", 8'h07, d);
    // inputs enabled after reset, so the data read shows the pins
    rd(SEL_P3_LATCH, d);
    chk("p3_latch", 8'hFF, d);
    rd(SEL_P3_DIR, d);
    chk("p3_dir", 8'h00, d);
  endtask

  task automatic t_port0();
    logic [7:0] d;
    p0_src = 8'hA5;
    // latch first, then drive select, as a pulse output setup orders them
    wr(SEL_P0_LATCH, 8'h0F);
    wr(SEL_P0_DRIVE, 8'hF0);
    chk("p0_oe_mix", 8'hF0, o_p0_oe);
    chk("p0_out_mix", 8'h0F, o_p0_out);
    rd(SEL_P0_PIN, d);
    chk("p0_pin", 8'h05, d);
    rd(SEL_P0_LATCH, d);
    chk("p0_latch_rd", 8'h0F, d);
    // latch ones first, then open-drain, before using the pins as inputs
    wr(SEL_P0_LATCH, 8'hFF);
    wr(SEL_P0_DRIVE, 8'h00);
    chk("p0_oe_in", 8'h00, o_p0_oe);
    rd(SEL_P0_PIN, d);
    chk("p0_pin_in", 8'hA5, d);
  endtask

  task automatic t_port1();
    logic [7:0] d;
    p1_src = 5'h13;
    wr(SEL_P1_LATCH, 8'hFF);
    wr(SEL_P1_DIR, 8'h05);
    chk("p1_oe", 8'h05, {3'h0, o_p1_oe});
    rd(SEL_P1_LATCH, d);
    chk("p1_mixed_rd", 8'h17, d);
    // write the read value back, as a bit operation would
    wr(SEL_P1_LATCH, d);
    wr(SEL_P1_DIR, 8'h1F);
    rd(SEL_P1_LATCH, d);
    chk("p1_rmw_latch", 8'h17, d);
    chk("p1_out", 8'h17, {3'h0, o_p1_out});
  endtask

  task automatic t_port2();
    logic [7:0] d;
    int         n;
    p2_src = 3'b101;
    rd(SEL_P2_PIN, d);
    chk("p2_pin", 8'h05, d);
    wr(SEL_P2_LATCH, 8'h02);
    chk("p2_oe_single", 8'h05, {5'h00, o_p2_oe});
    chk("p2_out", 8'h00, {5'h00, o_p2_out});
    i_dual_clock = 1'b1;
    settle();
    chk("p2_oe_dual", 8'h01, {5'h00, o_p2_oe});
    i_stop_output_hold = 1'b1;
    i_stop_mode = 1'b1;
    settle();
    chk("p2_oe_stop", 8'h00, {5'h00, o_p2_oe});
    i_stop_mode = 1'b0;
    wr(SEL_P2_LATCH, 8'h07);
    p2_src = 3'b111;
    settle();
    p2_src = 3'b110;
    n = 0;
    repeat (4) begin
      @(posedge i_clk);
      #1;
      if (o_p20_ext_int === 1'b1) n++;
    end
    chk("p20_int_pulses", 8'h01, 8'(n));
  endtask

  task automatic t_port3();
    logic [7:0] d;
    p3_src = 8'hFF;
    wr(SEL_P3_LATCH, 8'h5A);
    wr(SEL_P3_DIR, 8'h0F);
    wr(SEL_P3_INEN, 8'h33);
    chk("p3_oe", 8'h0F, o_p3_oe);
    chk("p3_out_low", 8'h0A, o_p3_out & 8'h0F);
    chk("p3_in_en", 8'h33, o_p3_in_en);
    rd(SEL_P3_LATCH, d);
    chk("p3_rd_mix", 8'h3A, d);
    wr(SEL_P3_DIR, 8'h00);
    wr(SEL_P3_INEN, 8'h00);
    // no port writes while the analog pin converts
    rd(SEL_P3_LATCH, d);
    chk("p3_rd_analog", 8'h00, d);
  endtask

  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    i_clk = 1'b0;
    i_rst = 1'b1;
    i_req = '{wr: 1'b0, rd: 1'b0, sel: SEL_NONE, wdata: 8'h00};
    i_dual_clock = 1'b0;
    i_stop_mode = 1'b0;
    i_stop_output_hold = 1'b0;
    p0_src = 8'hFF;
    p1_src = 5'h1F;
    p2_src = 3'h7;
    p3_src = 8'hFF;
    repeat (8) @(posedge i_clk);
    #1;
    i_rst = 1'b0;
    t_reset();
    t_port0();
    t_port1();
    t_port2();
    t_port3();
    end_of_test();
  end

  initial begin
    #20000;
    fails++;
    end_of_test();
  end
endmodule // tb_top
`default_nettype wire
